// ### rtl/sfc_pkg.sv
package sfc_pkg;

    localparam int          ADDR_W     = 17;
    localparam int          MEM_BYTES  = 131072;
    localparam int          FIFO_DEPTH = 16;
    localparam int          FIFO_W     = 8;

    localparam logic [7:0]  OP_SET_WL  = 8'h06;
    localparam logic [7:0]  OP_CLR_WL  = 8'h04;
    localparam logic [7:0]  OP_RD_STAT = 8'h05;
    localparam logic [7:0]  OP_WR_STAT = 8'h01;
    localparam logic [7:0]  OP_READ    = 8'h03;
    localparam logic [7:0]  OP_WRITE   = 8'h02;
    localparam logic [7:0]  OP_FAST_RD = 8'h0B;
    localparam logic [7:0]  OP_IDENT   = 8'h9F;
    localparam logic [7:0]  OP_SLEEP   = 8'hB9;

    localparam int          ST_LOCK    = 7;
    localparam int          ST_PSEL1   = 3;
    localparam int          ST_PSEL0   = 2;
    localparam int          ST_WLATCH  = 1;
    localparam int          ST_BUSY    = 0;

    localparam logic [16:0] PROT_QTR   = 17'h18000;
    localparam logic [16:0] PROT_HALF  = 17'h10000;
    localparam logic [16:0] ADDR_TOP   = 17'h1FFFF;
    localparam logic [16:0] ADDR_ZERO  = 17'h00000;

    localparam logic [4:0]  CNT_OP     = 5'h07;
    localparam logic [4:0]  CNT_ADDR   = 5'h17;
    localparam logic [4:0]  CNT_BYTE   = 5'h07;
    localparam logic [4:0]  CNT_ZERO   = 5'h00;

    // arbitrary neutral identification bytes
    localparam logic [7:0]  ID_BYTE0   = 8'h11;
    localparam logic [7:0]  ID_BYTE1   = 8'h22;
    localparam logic [7:0]  ID_BYTE2   = 8'h33;

    typedef enum logic [7:0] {
        SFC_IDLE  = 8'b0000_0001,
        SFC_OPC   = 8'b0000_0010,
        SFC_ADDR  = 8'b0000_0100,
        SFC_DUMMY = 8'b0000_1000,
        SFC_RDOUT = 8'b0001_0000,
        SFC_WRIN  = 8'b0010_0000,
        SFC_STWR  = 8'b0100_0000,
        SFC_SKIP  = 8'b1000_0000
    } sfc_state_e;

    typedef struct packed {
        logic        lock;
        logic [1:0]  psel;
        logic        wlatch;
    } sfc_stat_s;

    typedef struct packed {
        logic [16:0] addr;
        logic [7:0]  data;
    } sfc_wreq_s;

endpackage : sfc_pkg

// ### rtl/sfc_fifo.sv
`timescale 1ns/1ps
module sfc_fifo #(
    parameter int W = 25,
    parameter int D = 16
) (
    input  wire logic         clock,
    input  wire logic         sys_rst,
    input  wire logic         inValid,
    output logic              inReady,
    input  wire logic [W-1:0] inData,
    output logic              outValid,
    input  wire logic         outReady,
    output logic [W-1:0]      outData
);
    localparam int AW = $clog2(D);

    logic [W-1:0] mem [D];
    logic [AW:0]  wrPtr_ff;
    logic [AW:0]  rdPtr_ff;
    logic         empty;
    logic         full;

    assign empty    = (wrPtr_ff == rdPtr_ff);
    assign full     = (wrPtr_ff[AW-1:0] == rdPtr_ff[AW-1:0]) &&
                      (wrPtr_ff[AW] != rdPtr_ff[AW]);
    assign inReady  = !full;
    assign outValid = !empty;
    assign outData  = mem[rdPtr_ff[AW-1:0]];

    always_ff @(posedge clock) begin
        if (inValid && !full) begin
            mem[wrPtr_ff[AW-1:0]] <= inData;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            wrPtr_ff <= '0;
        end else if (inValid && !full) begin
            wrPtr_ff <= wrPtr_ff + 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rdPtr_ff <= '0;
        end else if (outReady && !empty) begin
            rdPtr_ff <= rdPtr_ff + 1'b1;
        end
    end

endmodule : sfc_fifo

// ### rtl/sfc_command_slave.sv
`timescale 1ns/1ps
// What this block does
// - operations run only while select is low; select high deselects.
// - serial input sampled on clock rise, output changes on clock fall.
// - pause low floats output and ignores input and clock.
// - hardware guard from lock bit combined with guard pin.
// - both idle-low and idle-high clock modes work.
// - unknown opcode: ignore rest of transfer until select rises.
// - set-latch command sets write latch; writes need it set.
// - clear-latch command clears write latch.
// - status read shifts status out, any time, repeatedly.
// - status write only takes effect when write latch is set.
// - status write changes only lock and both protect bits.
// - normal read: opcode, 24-bit address, then addressed bytes out.
// - fast read: opcode, address, one dummy byte, then data.
// - read address advances every 8 clocks, next byte follows.
// - read address wraps at top address.
// - ident and sleep opcodes are recognised.
// - array holds 131072 bytes, wrapping after the last.
// - protect bits select the write-shielded area.
// - 00 none, 01 upper quarter, 10 upper half, 11 all.
// - guard low with lock set rejects status writes.
// - memory write: opcode, address, data; ends at select rise.
// - write address increments and wraps to zero.
module sfc_command_slave (
    input  wire logic clock,
    input  wire logic sys_rst,
    input  wire logic chipSelectN,
    input  wire logic serialClk,
    input  wire logic serialIn,
    input  wire logic pauseN,
    input  wire logic writeGuardN,
    output logic      serialOut,
    output logic      serialOutOeN,
    output logic      writeBackpressure
);

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    logic [1:0] csSync_ff;
    logic [1:0] sckSync_ff;
    logic [1:0] siSync_ff;
    logic [1:0] holdSync_ff;
    logic [1:0] wpSync_ff;
    logic       sckPrev_ff;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            csSync_ff   <= 2'h3;
            sckSync_ff  <= 2'h0;
            siSync_ff   <= 2'h0;
            holdSync_ff <= 2'h3;
            wpSync_ff   <= 2'h3;
            sckPrev_ff  <= 1'b0;
        end else begin
            csSync_ff   <= {csSync_ff[0], chipSelectN};
            sckSync_ff  <= {sckSync_ff[0], serialClk};
            siSync_ff   <= {siSync_ff[0], serialIn};
            holdSync_ff <= {holdSync_ff[0], pauseN};
            wpSync_ff   <= {wpSync_ff[0], writeGuardN};
            sckPrev_ff  <= sckSync_ff[1];
        end
    end

    logic csN;
    logic si;
    logic held;
    logic guardN;
    logic sckRise;
    logic sckFall;

    assign csN     = csSync_ff[1];
    assign si      = siSync_ff[1];
    assign held    = !holdSync_ff[1];
    assign guardN  = wpSync_ff[1];
    // edges only count while selected and not paused; mode 3 idle-high
    // gives a fall before the first rise, which is harmless here
    assign sckRise = sckSync_ff[1] && !sckPrev_ff &&
                     !csN && !held;
    assign sckFall = !sckSync_ff[1] && sckPrev_ff &&
                     !csN && !held;

    ////////////////////////////////////////////////////////////////////////
    // array, status and shift state

    logic [7:0]             memArray [sfc_pkg::MEM_BYTES];
    sfc_pkg::sfc_stat_s     stat_ff;
    sfc_pkg::sfc_state_e    state_ff;
    logic [7:0]             opcode_ff;
    logic [7:0]             shIn_ff;
    logic [7:0]             shOut_ff;
    logic [4:0]             bitCnt_ff;
    logic [16:0]            addr_ff;
    logic [1:0]             idIdx_ff;
    logic                   outBit_ff;
    logic                   outEn_ff;

    logic [7:0]             statusByte;
    logic [7:0]             inByte;
    logic                   byteDone;
    logic                   rdByteDone;
    logic                   hardGuard;
    logic                   addrProt;
    logic [16:0]            nxt_addr;
    logic [7:0]             readByte;

    assign inByte     = {shIn_ff[6:0], si};
    assign byteDone   = sckRise && (bitCnt_ff == sfc_pkg::CNT_BYTE);
    assign hardGuard  = !guardN && stat_ff.lock;
    // top address rolls over to zero for reads and writes
    assign nxt_addr   = (addr_ff == sfc_pkg::ADDR_TOP) ?
                        sfc_pkg::ADDR_ZERO : addr_ff + 17'h00001;

    always_comb begin
        statusByte                     = 8'h00;
        statusByte[sfc_pkg::ST_LOCK]   = stat_ff.lock;
        statusByte[sfc_pkg::ST_PSEL1]  = stat_ff.psel[1];
        statusByte[sfc_pkg::ST_PSEL0]  = stat_ff.psel[0];
        statusByte[sfc_pkg::ST_WLATCH] = stat_ff.wlatch;
        statusByte[sfc_pkg::ST_BUSY]   = 1'b0;
    end

    function automatic logic isProt(input logic [1:0] psel,
                                    input logic [16:0] a);
        unique case (psel)
            2'h0: isProt = 1'b0;
            2'h1: isProt = (a >= sfc_pkg::PROT_QTR);
            2'h2: isProt = (a >= sfc_pkg::PROT_HALF);
            2'h3: isProt = 1'b1;
        endcase
    endfunction : isProt

    ////////////////////////////////////////////////////////////////////////
    // write path through the fifo

    sfc_pkg::sfc_wreq_s wrIn;
    sfc_pkg::sfc_wreq_s wrOut;
    logic               wrPush;
    logic               wrPushReady;
    logic               wrValid;

    assign wrIn.addr = addr_ff;
    assign wrIn.data = inByte;
    // data bytes are dropped unless the write latch was set first
    assign wrPush    = (state_ff == sfc_pkg::SFC_WRIN) && byteDone &&
                       stat_ff.wlatch;
    assign writeBackpressure = !wrPushReady;
    assign addrProt  = isProt(stat_ff.psel, wrOut.addr);

    sfc_fifo #(
        .W (sfc_pkg::ADDR_W + 8),
        .D (sfc_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clock    (clock),
        .sys_rst  (sys_rst),
        .inValid  (wrPush),
        .inReady  (wrPushReady),
        .inData   (wrIn),
        .outValid (wrValid),
        .outReady (1'b1),
        .outData  (wrOut)
    );

    always_ff @(posedge clock) begin
        if (wrValid && !addrProt) begin
            memArray[wrOut.addr] <= wrOut.data;
        end
    end

    assign readByte = memArray[addr_ff];

    ////////////////////////////////////////////////////////////////////////
    // command sequencer

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            shIn_ff <= 8'h00;
        end else if (sckRise) begin
            shIn_ff <= inByte;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst || csN) begin
            state_ff  <= sfc_pkg::SFC_IDLE;
            bitCnt_ff <= sfc_pkg::CNT_ZERO;
            opcode_ff <= 8'h00;
            idIdx_ff  <= 2'h0;
        end else begin
            unique case (state_ff)
                sfc_pkg::SFC_IDLE: begin
                    state_ff  <= sfc_pkg::SFC_OPC;
                    bitCnt_ff <= sfc_pkg::CNT_ZERO;
                end
                sfc_pkg::SFC_OPC: begin
                    if (sckRise) begin
                        bitCnt_ff <= bitCnt_ff + 5'h01;
                    end
                    if (byteDone) begin
                        opcode_ff <= inByte;
                        bitCnt_ff <= sfc_pkg::CNT_ZERO;
                        unique case (inByte)
                            sfc_pkg::OP_READ,
                            sfc_pkg::OP_FAST_RD,
                            sfc_pkg::OP_WRITE: state_ff <= sfc_pkg::SFC_ADDR;
                            sfc_pkg::OP_RD_STAT,
                            sfc_pkg::OP_IDENT:
                                state_ff <= sfc_pkg::SFC_RDOUT;
                            sfc_pkg::OP_WR_STAT: state_ff <= sfc_pkg::SFC_STWR;
                            sfc_pkg::OP_SET_WL,
                            sfc_pkg::OP_CLR_WL,
                            sfc_pkg::OP_SLEEP:  state_ff <= sfc_pkg::SFC_SKIP;
                            default:
                                state_ff <= sfc_pkg::SFC_SKIP;
                        endcase
                    end
                end
                sfc_pkg::SFC_ADDR: begin
                    if (sckRise) begin
                        bitCnt_ff <= bitCnt_ff + 5'h01;
                        if (bitCnt_ff == sfc_pkg::CNT_ADDR) begin
                            bitCnt_ff <= sfc_pkg::CNT_ZERO;
                            if (opcode_ff == sfc_pkg::OP_WRITE) begin
                                state_ff <= sfc_pkg::SFC_WRIN;
                            end else if (opcode_ff == sfc_pkg::OP_FAST_RD) begin
                                state_ff <= sfc_pkg::SFC_DUMMY;
                            end else begin
                                state_ff <= sfc_pkg::SFC_RDOUT;
                            end
                        end
                    end
                end
                sfc_pkg::SFC_DUMMY: begin
                    if (sckRise) begin
                        bitCnt_ff <= bitCnt_ff + 5'h01;
                    end
                    if (byteDone) begin
                        bitCnt_ff <= sfc_pkg::CNT_ZERO;
                        state_ff  <= sfc_pkg::SFC_RDOUT;
                    end
                end
                sfc_pkg::SFC_RDOUT, sfc_pkg::SFC_WRIN,
                sfc_pkg::SFC_STWR: begin
                    if (sckRise) begin
                        bitCnt_ff <= (bitCnt_ff == sfc_pkg::CNT_BYTE) ?
                                     sfc_pkg::CNT_ZERO : bitCnt_ff + 5'h01;
                    end
                    if (byteDone && state_ff == sfc_pkg::SFC_RDOUT &&
                        idIdx_ff != 2'h3) begin
                        idIdx_ff <= idIdx_ff + 2'h1;
                    end
                    if (byteDone && state_ff == sfc_pkg::SFC_STWR) begin
                        state_ff <= sfc_pkg::SFC_SKIP;
                    end
                end
                sfc_pkg::SFC_SKIP: begin
                    state_ff <= sfc_pkg::SFC_SKIP;
                end
                default: state_ff <= sfc_pkg::SFC_SKIP;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // address counter

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            addr_ff <= sfc_pkg::ADDR_ZERO;
        end else if (state_ff == sfc_pkg::SFC_ADDR && sckRise) begin
            addr_ff <= {addr_ff[15:0], si};
        end else if ((state_ff == sfc_pkg::SFC_RDOUT ||
                      state_ff == sfc_pkg::SFC_WRIN) && byteDone &&
                     opcode_ff != sfc_pkg::OP_RD_STAT &&
                     opcode_ff != sfc_pkg::OP_IDENT) begin
            addr_ff <= nxt_addr;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status register

    assign rdByteDone = (state_ff == sfc_pkg::SFC_OPC) && byteDone;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            stat_ff <= '0;
        end else if (rdByteDone && inByte == sfc_pkg::OP_SET_WL) begin
            stat_ff.wlatch <= 1'b1;
        end else if (rdByteDone && inByte == sfc_pkg::OP_CLR_WL) begin
            stat_ff.wlatch <= 1'b0;
        end else if (state_ff == sfc_pkg::SFC_STWR && byteDone &&
                     stat_ff.wlatch && !hardGuard) begin
            stat_ff.lock <= inByte[sfc_pkg::ST_LOCK];
            stat_ff.psel <= {inByte[sfc_pkg::ST_PSEL1],
                             inByte[sfc_pkg::ST_PSEL0]};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // serial output, changes on falling clock

    logic [7:0] loadByte;

    always_comb begin
        loadByte = readByte;
        if (opcode_ff == sfc_pkg::OP_RD_STAT) begin
            loadByte = statusByte;
        end else if (opcode_ff == sfc_pkg::OP_IDENT) begin
            unique case (idIdx_ff)
                2'h0:    loadByte = sfc_pkg::ID_BYTE0;
                2'h1:    loadByte = sfc_pkg::ID_BYTE1;
                default: loadByte = sfc_pkg::ID_BYTE2;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst || csN) begin
            shOut_ff  <= 8'h00;
            outBit_ff <= 1'b0;
            outEn_ff  <= 1'b0;
        end else if (sckFall && state_ff == sfc_pkg::SFC_RDOUT) begin
            outEn_ff <= 1'b1;
            if (bitCnt_ff == sfc_pkg::CNT_ZERO) begin
                outBit_ff <= loadByte[7];
                shOut_ff  <= {loadByte[6:0], 1'b0};
            end else begin
                outBit_ff <= shOut_ff[7];
                shOut_ff  <= {shOut_ff[6:0], 1'b0};
            end
        end
    end

    assign serialOut    = outBit_ff;
    assign serialOutOeN = !(outEn_ff && !held && !csN);

endmodule : sfc_command_slave

// ### verif/sfc_command_slave_sva.sv
`timescale 1ns/1ps
module sfc_checker (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic chipSelectN,
    input wire logic serialClk,
    input wire logic serialIn,
    input wire logic pauseN,
    input wire logic writeGuardN,
    input wire logic serialOut,
    input wire logic serialOutOeN,
    input wire logic writeBackpressure
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);

    a_reset_quiet: assert property (disable iff (1'b0)
        sys_rst ##1 sys_rst |-> serialOutOeN && !serialOut)
        else $error("output not quiet during reset");
    a_desel_float: assert property (
        chipSelectN [*5] |-> serialOutOeN)
        else $error("output driven while deselected");
    a_pause_float: assert property (!pauseN [*5] |-> serialOutOeN)
        else $error("output driven during pause");
    a_out_on_fall: assert property (
        (serialClk && !chipSelectN) [*4] |-> $stable(serialOut))
        else $error("output moved while link clock high");
    a_oe_needs_sel: assert property (
        $fell(serialOutOeN) |-> $past(!chipSelectN, 2))
        else $error("output enabled without select");
    a_oe_needs_run: assert property (
        $fell(serialOutOeN) |-> $past(pauseN, 2))
        else $error("output enabled during pause");
    a_oe_stands: assert property (
        (!chipSelectN && pauseN) [*3] ##0 !serialOutOeN |=> !serialOutOeN)
        else $error("output released mid transfer");
    a_no_backpress: assert property (!writeBackpressure)
        else $error("write path refused data");
endmodule : sfc_checker

bind sfc_command_slave sfc_checker u_chk (
    .clock             (clock),
    .sys_rst           (sys_rst),
    .chipSelectN       (chipSelectN),
    .serialClk         (serialClk),
    .serialIn          (serialIn),
    .pauseN            (pauseN),
    .writeGuardN       (writeGuardN),
    .serialOut         (serialOut),
    .serialOutOeN      (serialOutOeN),
    .writeBackpressure (writeBackpressure)
);

// ### verif/sfc_host_model.sv
`timescale 1ns/1ps
module sfc_host_model (
    input  wire logic clock,
    input  wire logic soLine,
    output logic      chipSelectN,
    output logic      serialClk,
    output logic      serialIn
);
    logic cpol;

    initial begin
        chipSelectN = 1'h1;
        serialClk   = 1'h0;
        serialIn    = 1'h0;
        cpol        = 1'h0;
    end

    // half period of 100 ns keeps the link far below its rate limits
    task automatic half();
        repeat (4) @(negedge clock);
    endtask : half

    task automatic open_frame(input logic mode);
        cpol = mode;
        serialClk <= mode;
        half();
        chipSelectN <= 1'h0;
        half();
    endtask : open_frame

    // data changes on the fall, read back just before the rise
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            serialClk <= 1'h0;
            serialIn  <= tx[i];
            half();
            rx[i] = soLine;
            serialClk <= 1'h1;
            half();
        end
    endtask : xfer

    // clock and data garbage while paused, ending at the same level
    task automatic wiggle(input logic [3:0] n);
        for (int i = 0; i < 2 * n; i++) begin
            serialClk <= ~serialClk;
            serialIn  <= ~serialIn;
            half();
        end
    endtask : wiggle

    task automatic close_frame();
        serialClk <= cpol;
        half();
        chipSelectN <= 1'h1;
        serialIn    <= ~serialIn;
        half();
    endtask : close_frame
endmodule : sfc_host_model

// ### verif/sfc_command_slave_tb.sv
`timescale 1ns/1ps
module sfc_command_slave_tb;
    typedef struct packed {
        logic        mode;
        logic        guard;
        logic [2:0]  n;
        logic [47:0] tx;
        logic [7:0]  exp;
        logic        chk;
    } sfc_row_s;

    logic       clock, sys_rst, pauseN, writeGuardN;
    logic       chipSelectN, serialClk, serialIn, soLine;
    logic       serialOut, serialOutOeN, writeBackpressure;
    logic [7:0] rx;
    int         checks, num_errors;
    sfc_row_s   rows[$];

    // released line shows the inverse of the last driven bit
    assign soLine = serialOutOeN ? ~serialOut : serialOut;

    sfc_command_slave dut (
        .clock             (clock),
        .sys_rst           (sys_rst),
        .chipSelectN       (chipSelectN),
        .serialClk         (serialClk),
        .serialIn          (serialIn),
        .pauseN            (pauseN),
        .writeGuardN       (writeGuardN),
        .serialOut         (serialOut),
        .serialOutOeN      (serialOutOeN),
        .writeBackpressure (writeBackpressure)
    );

    sfc_host_model u_host (
        .clock       (clock),
        .soLine      (soLine),
        .chipSelectN (chipSelectN),
        .serialClk   (serialClk),
        .serialIn    (serialIn)
    );

    initial begin
        clock = 1'h0;
        forever #12.5 clock = ~clock;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [7:0] e,
                         input logic [7:0] s);
        checks++;
        if (s !== e) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", what, e, s);
        end
    endtask : check

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : test_done

    task automatic add(input logic m, input logic g, input logic [2:0] n,
                       input logic [47:0] tx, input logic [7:0] e,
                       input logic c);
        rows.push_back('{m, g, n, tx, e, c});
    endtask : add

    task automatic run_row(input sfc_row_s r);
        u_host.open_frame(r.mode);
        for (int b = 0; b < r.n; b++)
            u_host.xfer(r.tx[47 - 8 * b -: 8], rx);
        u_host.close_frame();
        if (r.chk)
            check("read byte", r.exp, rx);
    endtask : run_row

    task automatic do_reset();
        sys_rst <= 1'h1;
        repeat (8) @(negedge clock);
        sys_rst <= 1'h0;
        @(negedge clock);
    endtask : do_reset

    ////////////////////////////////////////////////////////////////////////
    initial begin
        #2000000;
        num_errors++;
        test_done();
    end

    initial begin
        sys_rst     = 1'h1;
        pauseN      = 1'h1;
        writeGuardN = 1'h1;
        add(0, 1, 2, 48'h050000000000, 8'h00, 1);
        add(0, 1, 1, 48'h060000000000, 8'h00, 0);
        add(0, 1, 2, 48'h050000000000, 8'h02, 1);
        add(0, 1, 6, 48'h02000010A55A, 8'h00, 0);
        add(0, 1, 6, 48'h030000100000, 8'h5A, 1);
        add(1, 1, 6, 48'h0B0000100000, 8'hA5, 1);
        add(0, 1, 1, 48'h040000000000, 8'h00, 0);
        add(0, 1, 2, 48'h050000000000, 8'h00, 1);
        add(0, 1, 5, 48'h020000101100, 8'h00, 0);
        add(0, 1, 5, 48'h030000100000, 8'hA5, 1);
        add(0, 1, 1, 48'h060000000000, 8'h00, 0);
        add(0, 1, 6, 48'h0201FFFF1234, 8'h00, 0);
        add(0, 1, 6, 48'h0301FFFF0000, 8'h34, 1);
        add(0, 1, 2, 48'h01FF00000000, 8'h00, 0);
        add(0, 1, 2, 48'h050000000000, 8'h8E, 1);
        add(0, 1, 5, 48'h020000107700, 8'h00, 0);
        add(0, 1, 5, 48'h030000100000, 8'hA5, 1);
        add(0, 0, 2, 48'h010000000000, 8'h00, 0);
        add(0, 0, 2, 48'h050000000000, 8'h8E, 1);
        add(0, 1, 2, 48'h018400000000, 8'h00, 0);
        add(0, 1, 2, 48'h050000000000, 8'h86, 1);
        add(0, 1, 5, 48'h0201FFFF9900, 8'h00, 0);
        add(0, 1, 5, 48'h0301FFFF0000, 8'h12, 1);
        add(0, 1, 5, 48'h020000106600, 8'h00, 0);
        add(0, 1, 5, 48'h030000100000, 8'h66, 1);
        add(0, 1, 2, 48'h9F0000000000, 8'h11, 1);
        add(0, 1, 1, 48'hB90000000000, 8'h00, 0);
        add(1, 1, 2, 48'h050000000000, 8'h86, 1);
        do_reset();
        foreach (rows[i]) begin
            writeGuardN <= rows[i].guard;
            run_row(rows[i]);
        end
        $display("test command table done");

        u_host.open_frame(1'h0);
        u_host.xfer(8'hFF, rx);
        u_host.xfer(8'h05, rx);
        u_host.xfer(8'h00, rx);
        check("enable after bad op", 8'h01, {7'h00, serialOutOeN});
        u_host.close_frame();
        $display("test bad opcode done");

        u_host.open_frame(1'h0);
        u_host.xfer(8'h05, rx);
        u_host.xfer(8'h00, rx);
        pauseN <= 1'h0;
        u_host.wiggle(4'h8);
        check("enable in pause", 8'h01, {7'h00, serialOutOeN});
        pauseN <= 1'h1;
        u_host.half();
        u_host.xfer(8'h00, rx);
        check("status after pause", 8'h86, rx);
        u_host.close_frame();
        $display("test pause done");

        do_reset();
        run_row('{1'h0, 1'h1, 3'h2, 48'h050000000000,
                  8'h00, 1'h1});
        $display("test second reset done");
        test_done();
    end
endmodule : sfc_command_slave_tb
